// >>> core/urx_recv.sv
`timescale 1ns/1ps
module urx_recv
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial line
    input wire logic serial_rx_pin
);
    urx_fifo_if fif ();
    urx_fifo u_fifo (.clock(clock), .rst(rst), .f(fif));

    logic rx_s1_r;
    logic rx_s2_r;
    logic [7:0] ctrl_r;
    logic [11:0] baud_divider_value;
    logic [11:0] div_cnt_r;
    logic tick;
    logic [3:0] smp_r;
    logic [2:0] votes_r;
    logic [3:0] bit_cnt_r;
    logic [8:0] shift_r;
    logic par_r;
    logic prev_rx_r;
    logic dor_pend_r;
    logic dor_r;
    urx_pkg::urx_state_t state_r;
    logic enable;
    logic double_speed_sel;
    logic addr_filter_mode;
    logic [2:0] size_sel;
    logic [3:0] nbits;
    logic [3:0] smp_last;
    logic [3:0] vote_first;
    logic in_vote;
    logic vote_end;
    logic voted;
    logic bit_end;
    logic done;
    logic stop_val;
    logic frame_type;
    logic keep;
    logic par_err;
    logic [8:0] data_al;
    logic wb_hit;
    logic rd_pop;
    logic [3:0] smp_after_edge;
    logic [4:0] stat_bits;

    assign enable = ctrl_r[urx_pkg::ctl_en];
    assign double_speed_sel = ctrl_r[urx_pkg::ctl_dbl];
    // filter mode only gates received frames; there is no transmit path here
    assign addr_filter_mode = ctrl_r[urx_pkg::ctl_addr];
    assign size_sel = ctrl_r[urx_pkg::ctl_size_hi:urx_pkg::ctl_size_lo];
    // size 0..4 gives 5..9 data bits, larger codes mean nine; with parity 6..10
    assign nbits = (size_sel > 3'h4) ? 4'h9 : 4'(size_sel + 3'h5);
    // samples per bit and centre window by speed
    assign smp_last = double_speed_sel ? urx_pkg::smp_last_dbl : urx_pkg::smp_last_norm;
    assign vote_first = double_speed_sel ? urx_pkg::vote_first_dbl : urx_pkg::vote_first_norm;
    assign in_vote = (smp_r >= vote_first) && (smp_r <= 4'(vote_first + 4'h2));
    assign vote_end = tick && (smp_r == 4'(vote_first + 4'h2));
    assign bit_end = tick && (smp_r == smp_last);
    // the edge sample is number one, so the count resumes at two
    assign smp_after_edge = 4'(urx_pkg::smp_one + urx_pkg::smp_one);
    // two of three wins; last sample folded in combinationally
    assign voted = (votes_r[1] & votes_r[0]) | ((votes_r[1] | votes_r[0]) & rx_s2_r);

    // two-flop synchroniser on the pin
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end
        else
        begin
            rx_s1_r <= serial_rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    // sample tick at 16x or 8x bit rate from the divider
    assign tick = (div_cnt_r == 12'h000);
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            div_cnt_r <= 12'h000;
        else if (tick)
            div_cnt_r <= baud_divider_value;
        else
            div_cnt_r <= 12'(div_cnt_r - 12'h001);
    end

    // frame end and filter decision
    assign stop_val = voted;
    assign data_al = shift_r >> (4'h9 - nbits);
    // ninth bit for nine-bit frames, else first stop bit
    assign frame_type = (nbits == 4'h9) ? data_al[8] : stop_val;
    // type one is address; drop data frames while filtering
    assign keep = !addr_filter_mode || frame_type;
    assign done = (state_r == urx_pkg::urx_stop) && vote_end;
    assign par_err = ctrl_r[urx_pkg::ctl_par_en] &&
                     ((^data_al) ^ par_r ^ ctrl_r[urx_pkg::ctl_par_odd]);

    // receive state machine
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= urx_pkg::urx_idle;
            smp_r <= 4'h0;
            votes_r <= 3'h0;
            bit_cnt_r <= 4'h0;
            shift_r <= 9'h000;
            par_r <= 1'b0;
            prev_rx_r <= 1'b1;
        end
        else if (!enable)
        begin
            state_r <= urx_pkg::urx_idle;
            // follow the line so enabling onto a low line is no edge
            prev_rx_r <= rx_s2_r;
        end
        else if (tick)
        begin
            prev_rx_r <= rx_s2_r;
            smp_r <= (smp_r == smp_last) ? 4'h0 : 4'(smp_r + 4'h1);
            if (in_vote)
                votes_r <= {votes_r[1:0], rx_s2_r};
            unique case (state_r)
                urx_pkg::urx_idle:
                begin
                    // falling edge: this sample is number one
                    if (prev_rx_r && !rx_s2_r)
                    begin
                        state_r <= urx_pkg::urx_start;
                        smp_r <= smp_after_edge;
                    end
                end
                urx_pkg::urx_start:
                begin
                    // mostly-high centre means a noise spike
                    if (vote_end && voted)
                        state_r <= urx_pkg::urx_idle;
                    else if (bit_end)
                    begin
                        state_r <= urx_pkg::urx_data;
                        bit_cnt_r <= 4'h0;
                    end
                end
                urx_pkg::urx_data:
                begin
                    if (vote_end)
                        shift_r <= {voted, shift_r[8:1]};
                    if (bit_end)
                    begin
                        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                        if (bit_cnt_r == 4'(nbits - 4'h1))
                            state_r <= ctrl_r[urx_pkg::ctl_par_en] ?
                                       urx_pkg::urx_par : urx_pkg::urx_stop;
                    end
                end
                urx_pkg::urx_par:
                begin
                    if (vote_end)
                        par_r <= voted;
                    if (bit_end)
                        state_r <= urx_pkg::urx_stop;
                end
                urx_pkg::urx_stop:
                begin
                    // only first stop bit; hunt for a new edge after its votes
                    if (vote_end)
                    begin
                        // history keeps the last vote sample, so a low stop is no edge
                        state_r <= urx_pkg::urx_idle;
                    end
                end
                default:
                    state_r <= urx_pkg::urx_idle;
            endcase
        end
    end

    // overrun: frame arrives while buffer full; dropped frames do not count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            dor_pend_r <= 1'b0;
        else if (!enable)
            dor_pend_r <= 1'b0;
        else if (done && keep)
            dor_pend_r <= (fif.count == urx_pkg::fifo_depth) && !rd_pop;
    end

    // push frame with its error bits
    assign fif.wr = done && keep;
    assign fif.wdata = {dor_pend_r, par_err, !stop_val, data_al};
    assign fif.flush = !enable;
    assign fif.rd = rd_pop;

    // sticky overrun shown until the next successful store
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            dor_r <= 1'b0;
        else if (!enable)
            dor_r <= 1'b0;
        else if (done && keep)
            dor_r <= (fif.count == urx_pkg::fifo_depth) && !rd_pop;
    end

    // head frame flags in status order; overrun also shows a loss not yet stored
    always_comb
    begin
        stat_bits = 5'h00;
        stat_bits[urx_pkg::st_rxc] = 1'b1;
        stat_bits[urx_pkg::st_fe] = fif.rdata[9];
        stat_bits[urx_pkg::st_dor] = dor_r | fif.rdata[11];
        stat_bits[urx_pkg::st_pe] = fif.rdata[10];
        stat_bits[urx_pkg::st_b8] = fif.rdata[8];
    end

    // wishbone decode: one-cycle ack, reading data pops the buffer
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_pop = wb_hit && !wb_we_i && (wb_adr_i == urx_pkg::data_off);

    // control registers; byte lane 0 / lanes 0-1 only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r <= {urx_pkg::size_reset, 5'h00};
            baud_divider_value <= urx_pkg::baud_reset;
        end
        else if (wb_hit && wb_we_i)
        begin
            if (wb_adr_i == urx_pkg::ctrl_off && wb_sel_i[0])
                ctrl_r <= wb_dat_i[7:0];
            if (wb_adr_i == urx_pkg::baud_off)
            begin
                if (wb_sel_i[0])
                    baud_divider_value[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    baud_divider_value[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    // ack and read data
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h00000000;
            if (wb_hit && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    urx_pkg::ctrl_off: wb_dat_o <= {24'h000000, ctrl_r};
                    urx_pkg::baud_off: wb_dat_o <= {20'h00000, baud_divider_value};
                    urx_pkg::stat_off:
                        // flags valid only while a frame is readable
                        wb_dat_o <= (fif.count == 2'h0) ? 32'h00000000 :
                            {27'h0000000, stat_bits};
                    urx_pkg::data_off:
                        wb_dat_o <= (fif.count == 2'h0) ? 32'h00000000 :
                            {23'h000000, fif.rdata[8:0]};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// >>> core/urx_pkg.sv
package urx_pkg;
    // wishbone register byte offsets
    localparam logic [3:0] ctrl_off = 4'h0;
    localparam logic [3:0] baud_off = 4'h4;
    localparam logic [3:0] stat_off = 4'h8;
    localparam logic [3:0] data_off = 4'hc;
    // control field positions
    localparam int ctl_en = 0;
    localparam int ctl_dbl = 1;
    localparam int ctl_addr = 2;
    localparam int ctl_par_en = 3;
    localparam int ctl_par_odd = 4;
    localparam int ctl_size_lo = 5;
    localparam int ctl_size_hi = 7;
    // status field positions
    localparam int st_rxc = 0;
    localparam int st_fe = 1;
    localparam int st_dor = 2;
    localparam int st_pe = 3;
    localparam int st_b8 = 4;
    // sampling, frame size, buffer and reset constants
    localparam logic [3:0] smp_last_norm = 4'hf;
    localparam logic [3:0] smp_last_dbl = 4'h7;
    localparam logic [3:0] vote_first_norm = 4'h8;
    localparam logic [3:0] vote_first_dbl = 4'h4;
    localparam logic [3:0] smp_one = 4'h1;
    localparam logic [2:0] size_nine = 3'h7;
    localparam logic [2:0] size_five = 3'h0;
    localparam logic [1:0] fifo_depth = 2'h2;
    localparam logic [11:0] baud_reset = 12'h000;
    localparam logic [2:0] size_reset = 3'h3;
    typedef enum logic [2:0] {urx_idle, urx_start, urx_data, urx_par, urx_stop} urx_state_t;
endpackage

// >>> core/urx_fifo_if.sv
`timescale 1ns/1ps
interface urx_fifo_if;
    logic wr;
    logic [11:0] wdata;
    logic rd;
    logic flush;
    logic [11:0] rdata;
    logic [1:0] count;
    modport wr_side (output wr, output wdata, output rd, output flush,
                     input rdata, input count);
    modport mem_side (input wr, input wdata, input rd, input flush,
                      output rdata, output count);
endinterface

// >>> core/urx_fifo.sv
`timescale 1ns/1ps
// two-entry receive buffer; head word comes out of a register
module urx_fifo
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // buffer port
    urx_fifo_if.mem_side f
);
    logic [11:0] mem_r [0:1];
    logic [1:0] cnt_r;
    logic [11:0] head_r;
    logic wp_r;
    logic rp_r;
    logic do_wr;
    logic do_rd;

    assign do_rd = f.rd && (cnt_r != 2'h0);
    assign do_wr = f.wr && (cnt_r != urx_pkg::fifo_depth || do_rd);
    assign f.count = cnt_r;
    assign f.rdata = head_r;

    // pointers and count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
        end
        else if (f.flush)
        begin
            cnt_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
        end
        else
        begin
            if (do_wr)
                wp_r <= ~wp_r;
            if (do_rd)
                rp_r <= ~rp_r;
            cnt_r <= 2'(cnt_r + {1'b0, do_wr} - {1'b0, do_rd});
        end
    end

    // storage, no reset needed
    always_ff @(posedge clock)
    begin
        if (do_wr)
            mem_r[wp_r] <= f.wdata;
    end

    // registered head: write into empty or pop onto the second word
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            head_r <= 12'h000;
        else if (do_wr && (cnt_r == 2'h0 || (cnt_r == 2'h1 && do_rd)))
            head_r <= f.wdata;
        else if (do_rd)
            head_r <= mem_r[~rp_r];
    end
endmodule

// >>> testbench/urx_recv_chk.sv
`timescale 1ns/1ps
// bus answer and status shape, seen from the block's ports only
module urx_recv_chk
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // serial line
    input wire logic serial_rx_pin
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic req;
    logic rd_ack;
    logic st_rd;
    // helper terms; status reads matter most since errors ride with frames
    assign req = wb_cyc_i && wb_stb_i;
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign st_rd = rd_ack && wb_adr_i == urx_pkg::stat_off;
    a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    a_wr_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
        else $error("read data not zero on write");
    a_unmap_zero: assert property (rd_ack && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_stat_upper: assert property (st_rd |-> wb_dat_o[31:5] == 27'h0)
        else $error("status upper bits set");
    a_empty_clean: assert property (st_rd && !wb_dat_o[0] |-> wb_dat_o[4:0] == 5'h0)
        else $error("flags shown with empty buffer");
    a_data_upper: assert property (rd_ack && wb_adr_i == urx_pkg::data_off
        |-> wb_dat_o[31:9] == 23'h0)
        else $error("data upper bits set");
    c_data_rd: cover property (rd_ack && wb_adr_i == urx_pkg::data_off);
    c_fe_seen: cover property (st_rd && wb_dat_o[urx_pkg::st_fe]);
    c_b8_seen: cover property (st_rd && wb_dat_o[urx_pkg::st_b8]);
    c_start: cover property ($fell(serial_rx_pin));
endmodule

// >>> testbench/urx_tx_model.sv
`timescale 1ns/1ps
// remote transmitter: exact bit period, line idles high between frames
module urx_tx_model
(
    // clock
    input wire logic clock,
    // serial line
    output logic line
);
    initial line = 1'b1;
    // hold a level for c clocks; changes land just after an edge
    task automatic hold(input logic v, input int c);
        begin
            line <= v;
            repeat (c) @(posedge clock);
        end
    endtask
    // start, then n bits lsb first; last bit may be cut short for early start
    task automatic send(input logic [11:0] b, input int n, input int per, input int last);
        begin
            hold(1'b0, per);
            for (int i = 0; i < n - 1; i++)
                hold(b[i], per);
            hold(b[n - 1], last > 0 ? last : per);
            if (!b[n - 1])
                hold(1'b1, per); // back to idle after a bad stop
        end
    endtask
    // short low spike on an idle line
    task automatic glitch(input int c);
        begin
            hold(1'b0, c);
            hold(1'b1, 1);
        end
    endtask
endmodule

// >>> testbench/urx_recv_tb.sv
`timescale 1ns/1ps
// queue of kept frames compared with status and data reads
module urx_recv_tb;
    logic clock, rst, cyc, stb, we, ack, rx;
    logic [3:0] adr;
    logic [31:0] wdat, q, r, seed;
    logic [13:0] expq[$];
    int n_fail, compares, per, filt, gpar, godd, t, k;
    urx_tx_model tx (.clock(clock), .line(rx));
    urx_recv dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(q), .wb_ack_o(ack),
        .serial_rx_pin(rx));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle; idle edge first, hold until ack is sampled
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] o);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clock); while (ack !== 1'b1 && ++n < 20);
        o = q;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
            chk(32'h1, 32'h0);
    endtask
    task cfg(input int nd, input int dbl, input int f, input int p, input int odd);
        wb(1'b1, urx_pkg::ctrl_off, 32'(1 | dbl << 1 | f << 2 | p << 3 | odd << 4
            | (nd == 9 ? 4 : nd - 5) << 5), r);
        per = dbl ? 16 : 32; // divider 1: two clocks a sample
        filt = f;
        gpar = p;
        godd = odd;
    endtask
    // model decides whether the frame is kept and what status it carries
    task frame(input int nd, input logic [8:0] d, input logic stp, input int last);
        logic [11:0] b;
        int n;
        d = d & 9'((1 << nd) - 1);
        b = 12'(d);
        n = nd;
        if (gpar != 0)
            b[n++] = ^d ^ godd[0];
        b[n++] = stp;
        if (filt == 0 || (nd == 9 ? d[8] : stp))
            expq.push_back({nd == 9 && d[8], 2'h0, ~stp, 1'b1, d});
        tx.send(b, n, per, last);
    endtask
    task drain;
        logic [13:0] e;
        while (expq.size() > 0)
        begin
            e = expq.pop_front();
            wb(1'b0, urx_pkg::stat_off, 32'h0, r);
            chk(r, 32'(e[13:9]));
            wb(1'b0, urx_pkg::data_off, 32'h0, r);
            chk(r, 32'(e[8:0]));
        end
        wb(1'b0, urx_pkg::stat_off, 32'h0, r);
        chk(r, 32'h0);
        $display("test %0d done", t++);
    endtask
    initial
    begin
        repeat (40000) @(posedge clock);
        n_fail++;
        test_done;
    end
    initial
    begin
        {rst, cyc, stb, we, adr, wdat} = {1'b1, 39'h0};
        {seed, n_fail, compares, t, filt, gpar, godd, per} = {32'd55919, 224'h0};
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        wb(1'b0, urx_pkg::ctrl_off, 32'h0, r);
        chk(r, 32'h60);
        wb(1'b0, urx_pkg::baud_off, 32'h0, r);
        chk(r, 32'h0);
        wb(1'b1, 4'h3, 32'hff, r);
        wb(1'b0, 4'h3, 32'h0, r);
        chk(r, 32'h0);
        wb(1'b1, urx_pkg::baud_off, 32'h1, r);
        // every size, second frame starts before a full stop bit ends
        for (k = 5; k <= 9; k++)
        begin
            cfg(k, 0, 0, 0, 0);
            frame(k, 9'(rnd()), 1'b1, 26);
            frame(k, 9'(rnd()), 1'b1, 0);
            drain;
        end
        cfg(8, 0, 0, 0, 0);
        frame(8, 9'(rnd()), 1'b0, 0);
        drain;
        cfg(8, 1, 0, 0, 0);
        frame(8, 9'(rnd()), 1'b1, 0);
        frame(8, 9'(rnd()), 1'b1, 0);
        drain;
        cfg(8, 0, 0, 0, 0);
        tx.glitch(6);
        repeat (64) @(posedge clock);
        drain;
        // address filter with the ninth bit as frame type
        cfg(9, 0, 1, 0, 0);
        frame(9, 9'h0aa, 1'b1, 0);
        frame(9, 9'h1c3, 1'b1, 0);
        frame(9, 9'h055, 1'b1, 0);
        drain;
        cfg(9, 0, 0, 0, 0);
        frame(9, 9'h03c, 1'b1, 0);
        drain;
        // five bits: first stop bit is the frame type
        cfg(5, 0, 1, 0, 0);
        frame(5, 9'(rnd()), 1'b0, 0);
        drain;
        frame(5, 9'(rnd()), 1'b1, 0);
        drain;
        for (k = 0; k < 2; k++)
        begin
            cfg(9, 0, 0, 1, k);
            frame(9, 9'(rnd()), 1'b1, 0);
            drain;
        end
        test_done;
    end
endmodule
bind urx_recv urx_recv_chk chk (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .serial_rx_pin(serial_rx_pin));
